// ---- dv/rsw_host_model.sv ----
// Host model that watches the reset pin and toggles the kick line.
`timescale 1ns/10ps
module rsw_host_model #(
    parameter int unsigned PERIOD = 10
) (
    input  wire logic ref_clk,
    input  wire logic reset_n_pin,
    input  wire logic kick_en,
    output logic      kick
);
    int unsigned cnt_q;

    initial begin
        kick = 1'b0;
        cnt_q = 0;
    end

    // A host held in reset runs no code, so it cannot kick either.
    always @(posedge ref_clk) begin
        if (!kick_en || reset_n_pin !== 1'b1) begin
            cnt_q <= 0;
        end else if (cnt_q == PERIOD - 1) begin
            cnt_q <= 0;
            kick  <= ~kick;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the reset supervisor watchdog.
`timescale 1ns/10ps
module tb;
    localparam int RST_N = 50;
    localparam int WD_N  = 200;
    localparam int WC_N  = 20;
    logic ref_clk;
    logic rst;
    logic supply_ok;
    logic button_n;
    logic ext_low;
    logic pin_n;
    logic kick;
    logic kick_en;
    logic wp;
    logic txn;
    logic wr_start;
    logic rn_out;
    logic rn_oe;
    logic rh_out;
    logic rh_oe;
    logic mem_en;
    logic abort;
    logic wr_go;
    logic wr_busy;
    int   error_cnt;
    int   cmp_count;
    int   cyc_cnt;

    // Pulled up; low when the device or the bench pulls it down.
    assign pin_n = !((rn_oe === 1'b1 && rn_out === 1'b0) || ext_low);

    rsw_top #(.RST_CYCLES(RST_N), .WD_CYCLES(WD_N), .WC_CYCLES(WC_N),
        .USE_KICK(1'b1)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .supply_ok(supply_ok),
        .pushbutton_reset_n(button_n), .reset_pin_n_in(pin_n),
        .watchdog_kick_in(kick), .sda_in(1'b1), .write_protect(wp),
        .mem_txn_req(txn), .mem_write_start(wr_start),
        .reset_n_out(rn_out), .reset_n_oe(rn_oe), .reset_hi_out(rh_out),
        .reset_hi_oe(rh_oe), .mem_enable(mem_en), .mem_abort(abort),
        .mem_write_go(wr_go), .mem_write_busy(wr_busy));

    rsw_host_model #(.PERIOD(10)) host_u (.ref_clk(ref_clk),
        .reset_n_pin(pin_n), .kick_en(kick_en), .kick(kick));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // The ceiling sits well above the under two thousand cycles the run needs.
    always @(posedge ref_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 10000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic chk(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return rn_oe;
            1: return wr_go;
            2: return wr_busy;
            default: return abort;
        endcase
    endfunction

    // Checks one output at each falling edge for n cycles, plus reset_hi_oe and mem_enable when it is reset_n_oe.
    task automatic hold(input string w, input int s, input logic v,
                        input int n);
        repeat (n) begin
            @(negedge ref_clk);
            chk(w, v, pick(s));
            if (s == 0) begin
                chk("reset_hi_oe", v, rh_oe);
                chk("mem_enable", !v, mem_en);
            end
        end
    endtask

    // Bounded wait, so a stuck design cannot hang the run.
    task automatic wait_for(input string w, input int s, input logic v,
                            input int lim);
        int n;
        n = 0;
        // Start at a falling edge so the value read is settled, not racing
        // the rising edge that launched it.
        @(negedge ref_clk);
        while (pick(s) !== v && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        chk(w, v, pick(s));
    endtask

    task automatic release_chk(input int lim);
        hold("reset_n_oe", 0, 1'b1, RST_N - 8);
        wait_for("reset_n_oe", 0, 1'b0, lim);
    endtask

    task automatic t_supply();
        hold("reset_n_oe", 0, 1'b1, 20);
        @(posedge ref_clk);
        supply_ok <= 1'b1;
        release_chk(25);
        chk("reset_n_out", 1'b0, rn_out);
        chk("reset_hi_out", 1'b1, rh_out);
        @(posedge ref_clk);
        supply_ok <= 1'b0;
        @(posedge ref_clk);
        supply_ok <= 1'b1;
        hold("reset_n_oe", 0, 1'b0, 20);
        @(posedge ref_clk);
        supply_ok <= 1'b0;
        wait_for("reset_n_oe", 0, 1'b1, 8);
        hold("reset_n_oe", 0, 1'b1, 30);
        @(posedge ref_clk);
        supply_ok <= 1'b1;
        release_chk(25);
    endtask

    task automatic t_button();
        @(posedge ref_clk);
        button_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        button_n <= 1'b1;
        hold("reset_n_oe", 0, 1'b0, 20);
        @(posedge ref_clk);
        button_n <= 1'b0;
        wait_for("reset_n_oe", 0, 1'b1, 10);
        @(posedge ref_clk);
        txn <= 1'b1;
        wr_start <= 1'b1;
        hold("mem_write_go", 1, 1'b0, 5);
        hold("mem_abort", 3, 1'b1, 3);
        hold("reset_n_oe", 0, 1'b1, 100);
        @(posedge ref_clk);
        txn <= 1'b0;
        wr_start <= 1'b0;
        button_n <= 1'b1;
        release_chk(25);
    endtask

    task automatic t_pin();
        @(posedge ref_clk);
        ext_low <= 1'b1;
        repeat (3) @(posedge ref_clk);
        ext_low <= 1'b0;
        wait_for("reset_n_oe", 0, 1'b1, 10);
        release_chk(25);
    endtask

    task automatic t_watchdog();
        hold("reset_n_oe", 0, 1'b0, 3 * WD_N);
        @(posedge ref_clk);
        kick_en <= 1'b0;
        hold("reset_n_oe", 0, 1'b0, WD_N - 30);
        wait_for("reset_n_oe", 0, 1'b1, 50);
        release_chk(25);
        hold("reset_n_oe", 0, 1'b0, WD_N - 40);
        @(posedge ref_clk);
        kick_en <= 1'b1;
    endtask

    task automatic t_write();
        @(posedge ref_clk);
        wp <= 1'b1;
        wr_start <= 1'b1;
        hold("mem_write_go", 1, 1'b0, 6);
        @(posedge ref_clk);
        wp <= 1'b0;
        wait_for("mem_write_go", 1, 1'b1, 5);
        @(posedge ref_clk);
        wr_start <= 1'b0;
        button_n <= 1'b0;
        hold("mem_write_busy", 2, 1'b1, WC_N - 4);
        wait_for("mem_write_busy", 2, 1'b0, 10);
        @(posedge ref_clk);
        button_n <= 1'b1;
        release_chk(25);
    endtask

    initial begin
        error_cnt = 0;
        cmp_count = 0;
        cyc_cnt = 0;
        rst = 1'b1;
        supply_ok = 1'b0;
        button_n = 1'b1;
        ext_low = 1'b0;
        kick_en = 1'b1;
        wp = 1'b0;
        txn = 1'b0;
        wr_start = 1'b0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        t_supply();
        t_button();
        t_pin();
        t_watchdog();
        t_write();
        stop_test();
    end
endmodule

// ---- hdl/rsw_filt.sv ----
// Synchroniser and glitch filter for one asynchronous level input.
`timescale 1ns/10ps
`include "rsw_map.svh"
module rsw_filt
    import rsw_pkg::*;
#(
    parameter int unsigned LEN   = 3,
    parameter logic        INIT  = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst,
    rsw_filt_if.filt f
);
    typedef struct packed {
        logic                  s1;
        logic                  s2;
        logic                  clean;
        logic [`RSW_FLT_W-1:0] cnt;
    } rsw_flt_st_t;
    rsw_flt_st_t st_q;
    rsw_flt_st_t st_d;

    // The output only moves once the new level held LEN cycles in a row.
    always_comb begin
        st_d = st_q;
        st_d.s1 = f.raw;
        st_d.s2 = st_q.s1;
        if (st_q.s2 == st_q.clean) begin
            st_d.cnt = '0;
        end else if (st_q.cnt >= LEN[`RSW_FLT_W-1:0] - 4'h1) begin
            st_d.clean = st_q.s2;
            st_d.cnt   = '0;
        end else begin
            st_d.cnt = st_q.cnt + 4'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q <= '{s1: INIT, s2: INIT, clean: INIT, cnt: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign f.clean = st_q.clean;
endmodule

// ---- hdl/rsw_filt_if.sv ----
// Carrier between the top and its input filter blocks.
`timescale 1ns/10ps
interface rsw_filt_if;
    logic raw;
    logic clean;
    modport filt (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// ---- hdl/rsw_map.svh ----
// Timing counts and fixed values of the reset supervisor watchdog.
`ifndef RSW_MAP_SVH
`define RSW_MAP_SVH
`define RSW_CLK_HZ        25000000
`define RSW_RST_TIME_MS   200
`define RSW_RST_CYCLES    ((`RSW_CLK_HZ / 1000) * `RSW_RST_TIME_MS)
`define RSW_WD_TIME_MS    1600
`define RSW_WD_CYCLES     ((`RSW_CLK_HZ / 1000) * `RSW_WD_TIME_MS)
`define RSW_GLITCH_NS     100
`define RSW_GLITCH_CYCLES ((`RSW_GLITCH_NS * 25 + 999) / 1000)
`define RSW_VDIP_CYCLES   1
`define RSW_WC_TIME_MS    5
`define RSW_WC_CYCLES     ((`RSW_CLK_HZ / 1000) * `RSW_WC_TIME_MS)
`define RSW_CNT_W         26
`define RSW_FLT_W         4
`endif

// ---- hdl/rsw_pkg.sv ----
// Types shared by the reset supervisor watchdog modules.
package rsw_pkg;
    typedef enum logic [2:0] {
        RSW_HOLD    = 3'h1,
        RSW_TIMEOUT = 3'h2,
        RSW_RUN     = 3'h4
    } rsw_state_t;
endpackage

// ---- hdl/rsw_top.sv ----
// Reset supervisor with manual reset, watchdog and memory guard.
`timescale 1ns/10ps
`include "rsw_map.svh"
module rsw_top
    import rsw_pkg::*;
#(
    parameter int unsigned RST_CYCLES = `RSW_RST_CYCLES,
    parameter int unsigned WD_CYCLES  = `RSW_WD_CYCLES,
    parameter int unsigned WC_CYCLES  = `RSW_WC_CYCLES,
    parameter logic        USE_KICK   = 1'b1
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic supply_ok,
    input  wire logic pushbutton_reset_n,
    input  wire logic reset_pin_n_in,
    input  wire logic watchdog_kick_in,
    input  wire logic sda_in,
    input  wire logic write_protect,
    input  wire logic mem_txn_req,
    input  wire logic mem_write_start,
    output logic      reset_n_out,
    output logic      reset_n_oe,
    output logic      reset_hi_out,
    output logic      reset_hi_oe,
    output logic      mem_enable,
    output logic      mem_abort,
    output logic      mem_write_go,
    output logic      mem_write_busy
);
    typedef struct packed {
        rsw_state_t            state;
        logic [`RSW_CNT_W-1:0] tmr;
        logic [`RSW_CNT_W-1:0] wd;
        logic [`RSW_CNT_W-1:0] wc;
        logic                  pin_s1;
        logic                  pin_s2;
        logic                  pin_prev;
        logic                  wd_s1;
        logic                  wd_s2;
        logic                  wd_prev;
        logic                  rst_act;
        logic                  abort;
        logic                  wgo;
    } rsw_st_t;
    rsw_st_t st_q;
    rsw_st_t st_d;

    rsw_filt_if sup_if ();
    rsw_filt_if btn_if ();

    logic sup_good;
    logic btn_low;
    logic pin_fall;
    logic wd_edge;
    logic wd_line;

    assign sup_if.raw = supply_ok;
    assign btn_if.raw = pushbutton_reset_n;

    // Brief supply dips die in the filter before they reach the state.
    rsw_filt #(
        .LEN  (`RSW_VDIP_CYCLES + 1),
        .INIT (1'b0)
    ) u_sup_filt (
        .ref_clk (ref_clk),
        .rst     (rst),
        .f       (sup_if)
    );

    // Three cycles at 40 ns passes only lows longer than 100 ns.
    rsw_filt #(
        .LEN  (`RSW_GLITCH_CYCLES),
        .INIT (1'b1)
    ) u_btn_filt (
        .ref_clk (ref_clk),
        .rst     (rst),
        .f       (btn_if)
    );

    assign sup_good = sup_if.clean;
    assign btn_low  = ~btn_if.clean;
    // The pin reads our own drive too, so only edges seen while released
    // count as external requests.
    assign pin_fall = st_q.pin_prev & ~st_q.pin_s2 & ~st_q.rst_act;
    assign wd_line  = USE_KICK ? watchdog_kick_in : sda_in;
    assign wd_edge  = st_q.wd_s2 ^ st_q.wd_prev;

    always_comb begin
        st_d = st_q;
        st_d.pin_s1   = reset_pin_n_in;
        st_d.pin_s2   = st_q.pin_s1;
        st_d.pin_prev = st_q.pin_s2;
        st_d.wd_s1    = wd_line;
        st_d.wd_s2    = st_q.wd_s1;
        st_d.wd_prev  = st_q.wd_s2;
        st_d.wgo      = 1'b0;
        case (st_q.state)
            RSW_HOLD: begin
                st_d.tmr = '0;
                if (sup_good && !btn_low) begin
                    st_d.state = RSW_TIMEOUT;
                end
            end
            RSW_TIMEOUT: begin
                if (!sup_good || btn_low) begin
                    st_d.state = RSW_HOLD;
                end else if (st_q.tmr >= RST_CYCLES[`RSW_CNT_W-1:0]
                             - 26'h1) begin
                    st_d.state = RSW_RUN;
                end else begin
                    st_d.tmr = st_q.tmr + 26'h1;
                end
            end
            RSW_RUN: begin
                st_d.tmr = '0;
                if (!sup_good || btn_low) begin
                    st_d.state = RSW_HOLD;
                end else if (pin_fall) begin
                    st_d.state = RSW_TIMEOUT;
                end else if (st_q.wd >= WD_CYCLES[`RSW_CNT_W-1:0]
                             - 26'h1) begin
                    st_d.state = RSW_TIMEOUT;
                end
            end
            default: begin
                st_d.state = RSW_HOLD;
            end
        endcase
        st_d.rst_act = (st_d.state != RSW_RUN);
        if (st_d.rst_act || wd_edge) begin
            st_d.wd = '0;
        end else begin
            st_d.wd = st_q.wd + 26'h1;
        end
        st_d.abort = st_d.rst_act & mem_txn_req;
        // A running write cycle always finishes; reset only gates new ones.
        if (st_q.wc != '0) begin
            st_d.wc = st_q.wc - 26'h1;
        end else if (mem_write_start && !st_q.rst_act
                     && !write_protect) begin
            st_d.wc  = WC_CYCLES[`RSW_CNT_W-1:0];
            st_d.wgo = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q <= '{state: RSW_HOLD, tmr: '0, wd: '0, wc: '0,
                      pin_s1: 1'b1, pin_s2: 1'b1, pin_prev: 1'b1,
                      wd_s1: 1'b0, wd_s2: 1'b0, wd_prev: 1'b0,
                      rst_act: 1'b1, abort: 1'b0, wgo: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    // Open-drain pins: output level is always the active level, only the
    // enable moves, so both polarities follow one flop.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reset_n_out    <= 1'b0;
            reset_n_oe     <= 1'b1;
            reset_hi_out   <= 1'b1;
            reset_hi_oe    <= 1'b1;
            mem_enable     <= 1'b0;
            mem_abort      <= 1'b0;
            mem_write_go   <= 1'b0;
            mem_write_busy <= 1'b0;
        end else begin
            reset_n_out    <= 1'b0;
            reset_n_oe     <= st_d.rst_act;
            reset_hi_out   <= 1'b1;
            reset_hi_oe    <= st_d.rst_act;
            mem_enable     <= ~st_d.rst_act;
            mem_abort      <= st_d.abort;
            mem_write_go   <= st_d.wgo;
            mem_write_busy <= (st_d.wc != '0);
        end
    end

    chk_hold_no_supply: assert property (@(posedge ref_clk) disable iff (rst)
        !sup_good |=> reset_n_oe)
        else $error("Reset released while supply bad.");
    chk_button_holds: assert property (@(posedge ref_clk) disable iff (rst)
        btn_low |=> reset_n_oe && reset_hi_oe)
        else $error("Reset released while button low.");
    chk_pols_together: assert property (@(posedge ref_clk) disable iff (rst)
        reset_n_oe == reset_hi_oe)
        else $error("Reset polarities differ.");
    chk_timeout_full: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(st_q.state == RSW_TIMEOUT) |-> st_q.tmr == '0)
        else $error("Timeout started with stale count.");
    chk_release_end: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(reset_n_oe) |-> $past(st_q.tmr) >= 
        RST_CYCLES[`RSW_CNT_W-1:0] - 26'h1)
        else $error("Reset released before timeout.");
    chk_wd_cleared: assert property (@(posedge ref_clk) disable iff (rst)
        st_q.rst_act |-> st_q.wd == '0)
        else $error("Watchdog counted during reset.");
    chk_wd_fires: assert property (@(posedge ref_clk) disable iff (rst)
        st_q.state == RSW_RUN && sup_good && !btn_low && !pin_fall
        && st_q.wd == WD_CYCLES[`RSW_CNT_W-1:0] - 26'h1
        |=> st_q.state == RSW_TIMEOUT)
        else $error("Watchdog expiry missed.");
    chk_no_write_wp: assert property (@(posedge ref_clk) disable iff (rst)
        write_protect |=> !st_q.wgo)
        else $error("Write started while protected.");
    chk_mem_off: assert property (@(posedge ref_clk) disable iff (rst)
        reset_n_oe |-> !mem_enable)
        else $error("Memory enabled during reset.");
    chk_write_runs: assert property (@(posedge ref_clk) disable iff (rst)
        st_q.wc > 26'h1 |=> st_q.wc == $past(st_q.wc) - 26'h1)
        else $error("Write cycle aborted.");
endmodule
